/* File: design/aocf_ext_mem.sv */
// Byte store behind the subaddress index extension.
// Assumes the caller keeps addresses in range and holds them a cycle ahead.
`timescale 1ns/1ns
`default_nettype none

module aocf_ext_mem #(
  parameter int BYTES = 131072
) (
  input  wire logic                     core_clk_in,
  input  wire logic                     ce_in,
  input  wire logic                     wr_in,
  input  wire logic [$clog2(BYTES)-1:0] addr_in,
  input  wire logic [7:0]               wdata_in,
  output var  logic [7:0]               rdata_out
);

  localparam int AW = $clog2(BYTES);

  initial begin
    if (BYTES < 2 || BYTES > 131072 || (1 << AW) != BYTES) begin
      $error("aocf_ext_mem: BYTES must be a power of two, 2 to 131072");
    end
  end

  logic [7:0] mem [BYTES];

  // Registered read, so the address must settle one cycle early
  always_ff @(posedge core_clk_in) begin
    if (ce_in) begin
      if (wr_in) begin
        mem[addr_in] <= wdata_in;
      end
      rdata_out <= mem[addr_in];
    end
  end

endmodule // aocf_ext_mem

`default_nettype wire

/* File: design/aocf_top.sv */
// Option-select configuration bank reached by setup cycles on the bus pins.
// Assumes one clock; bus pins are asynchronous and are synchronised here.
`timescale 1ns/1ns
`default_nettype none
`include "aocf_regs.svh"

module aocf_top
  import aocf_pkg::*;
#(
  parameter logic [15:0] ADAPTER_ID  = 16'h5A5A,  // Arbitrary value
  parameter logic [7:0]  IO_SEL_PAGE = 8'h03,
  parameter bit          CHANNEL_CHECK_SIGNAL_IMPL   = 1'b1,
  parameter int          EXT_BYTES   = 131072
) (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic        channel_reset_in,
  input  wire logic        card_setup_select_n_in,
  input  wire logic        cmd_n_in,
  input  wire logic        write_in,
  input  wire logic        m_io_in,
  input  wire logic [15:0] io_addr_in,
  input  wire logic [7:0]  data_in,
  input  wire logic [31:13] mem_addr_in,
  input  wire logic        channel_check_signal_event_in,
  input  wire logic [15:0] channel_check_signal_status_in,
  input  wire logic        sfdbk_missing_in,
  input  wire logic        strobe_req_in,
  input  wire logic        parity_active_in,
  output var  logic [7:0]  data_out,
  output var  logic        data_oe_out,
  output var  logic        card_enable_out,
  output var  logic        bus_enable_out,
  output var  logic [2:0]  io_addr_select_out,
  output var  logic [3:0]  mem_window_out,
  output var  logic [3:0]  arb_level_out,
  output var  logic        fairness_en_out,
  output var  logic        matched_mem_en_out,
  output var  logic        streaming_en_out,
  output var  logic [5:0]  dev_addr_out,
  output var  logic        io_hit_out,
  output var  logic [7:0]  reg_select_out,
  output var  logic        mem_hit_out,
  output var  logic        data_parity_valid_n_out,
  output var  logic        address_parity_valid_n_out,
  output var  logic        data_parity_check_out,
  output var  logic        address_parity_check_out,
  output var  logic        streaming_strobe_oe_out,
  output var  logic        sfdbk_exception_out,
  output var  logic        channel_check_signal_n_out,
  output var  logic        channel_check_signal_oe_out
);

  localparam int          AW      = $clog2(EXT_BYTES);
  localparam logic [17:0] EXT_LIM = 18'(EXT_BYTES);

  initial begin
    if (EXT_BYTES < 2 || EXT_BYTES > 131072) begin
      $error("aocf_top: EXT_BYTES must lie in 2 to 131072");
    end
  end

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // Address and data ride the same two stages; the command edge is
  // only acted on after they have been stable on the bus for a while.
  logic [47:0] pin_meta;
  logic [47:0] pin_sync;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pin_meta <= `AOCF_PIN_IDLE;
      pin_sync <= `AOCF_PIN_IDLE;
    end else if (ce_in) begin
      pin_meta <= {channel_reset_in, card_setup_select_n_in, cmd_n_in, write_in,
                   m_io_in, io_addr_in, data_in, mem_addr_in};
      pin_sync <= pin_meta;
    end
  end

  logic        s_channel_reset;
  logic        s_setup_n;
  logic        s_cmd_n;
  logic        s_write;
  logic        s_mio;
  logic [15:0] s_io_addr;
  logic [7:0]  s_data;
  logic [18:0] s_mem_addr;

  assign s_channel_reset  = pin_sync[47];
  assign s_setup_n  = pin_sync[46];
  assign s_cmd_n    = pin_sync[45];
  assign s_write    = pin_sync[44];
  assign s_mio      = pin_sync[43];
  assign s_io_addr  = pin_sync[42:27];
  assign s_data     = pin_sync[26:19];
  assign s_mem_addr = pin_sync[18:0];

  logic field_rst;
  assign field_rst = rst_in | s_channel_reset;

  // ****************************************************************
  // Setup-cycle sequencing
  // ****************************************************************

  aocf_setup_state_t state;
  logic              cmd_prev;
  logic [2:0]        acc_reg;
  logic              acc_wr;
  logic              start;
  logic              finish;

  assign start  = (state == AOCF_IDLE) & ~s_setup_n & ~s_mio & cmd_prev & ~s_cmd_n;
  assign finish = (state == AOCF_HOLD) & (s_cmd_n | s_setup_n);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state    <= AOCF_IDLE;
      cmd_prev <= 1'b1;
      acc_reg  <= 3'h0;
      acc_wr   <= 1'b0;
    end else if (ce_in) begin
      cmd_prev <= s_cmd_n;
      case (state)
        AOCF_IDLE: begin
          if (start) begin
            state   <= AOCF_CAPT;
            acc_reg <= s_io_addr[2:0];
            acc_wr  <= s_write;
          end
        end
        AOCF_CAPT: begin
          state <= AOCF_HOLD;
        end
        AOCF_HOLD: begin
          if (s_cmd_n | s_setup_n) begin
            state <= AOCF_IDLE;
          end
        end
        default: begin
          state <= AOCF_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Option bytes
  // ****************************************************************

  logic [7:0]  byte1;
  logic [7:0]  byte2;
  logic [7:0]  byte3;
  logic [5:0]  byte4_lo;
  logic        chk_flag;
  logic        chk_ind;
  logic [15:0] index;
  logic [15:0] chk_status;

  logic        wr_now;
  logic        idx_zero;
  logic        lane_sel;
  logic        ext_reg;
  logic        ext_ok;
  logic        ext_wr;
  logic [7:0]  ext_rdata;

  assign wr_now   = start & s_write;
  assign idx_zero = (index == 16'h0000);
  assign lane_sel = (s_io_addr[2:0] == `AOCF_REG_BYTE3);
  assign ext_reg  = (s_io_addr[2:0] == `AOCF_REG_BYTE2) | lane_sel;
  assign ext_ok   = ({1'b0, index, lane_sel} < EXT_LIM);
  assign ext_wr   = wr_now & ext_reg & ~idx_zero & ext_ok;

  always_ff @(posedge core_clk_in) begin
    if (field_rst) begin
      byte1 <= `AOCF_RST_BYTE1;
      byte2 <= `AOCF_RST_BYTE2;
      byte3 <= `AOCF_RST_BYTE3;
    end else if (ce_in && wr_now) begin
      case (s_io_addr[2:0])
        `AOCF_REG_BYTE1: byte1 <= s_data;
        `AOCF_REG_BYTE2: begin
          if (idx_zero) begin
            byte2 <= s_data;
          end
        end
        `AOCF_REG_BYTE3: begin
          if (idx_zero) begin
            byte3 <= s_data;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Indicator follows the flag when channel check exists; otherwise
  // bit 6 is plain configuration storage.
  always_ff @(posedge core_clk_in) begin
    if (field_rst) begin
      byte4_lo   <= `AOCF_RST_BYTE4_LO;
      chk_flag   <= `AOCF_RST_CHK_FLAG;
      chk_ind    <= `AOCF_RST_CHK_IND;
      chk_status <= 16'h0000;
    end else if (ce_in) begin
      if (wr_now && s_io_addr[2:0] == `AOCF_REG_BYTE4) begin
        byte4_lo <= s_data[5:0];
        if (!CHANNEL_CHECK_SIGNAL_IMPL) begin
          chk_ind <= s_data[`AOCF_B4_CHK_IND];
        end
      end
      if (CHANNEL_CHECK_SIGNAL_IMPL && channel_check_signal_event_in && chk_flag) begin
        chk_flag   <= 1'b0;
        chk_ind    <= 1'b0;
        chk_status <= channel_check_signal_status_in;
      end else if (CHANNEL_CHECK_SIGNAL_IMPL && wr_now && s_io_addr[2:0] == `AOCF_REG_BYTE4 &&
                   s_data[`AOCF_B4_CHK_FLAG]) begin
        chk_flag <= 1'b1;
        chk_ind  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Subaddress index
  // ****************************************************************

  always_ff @(posedge core_clk_in) begin
    if (field_rst) begin
      index <= `AOCF_RST_INDEX;
    end else if (ce_in) begin
      if (wr_now && s_io_addr[2:0] == `AOCF_REG_IDX_LO) begin
        index[7:0] <= s_data;
      end else if (wr_now && s_io_addr[2:0] == `AOCF_REG_IDX_HI) begin
        index[15:8] <= s_data;
      end else if (finish && byte3[`AOCF_B3_AUTOINC] &&
                   (acc_reg == `AOCF_REG_BYTE2 || acc_reg == `AOCF_REG_BYTE3)) begin
        index <= index + 16'h0001;
      end
    end
  end

  aocf_ext_mem #(
    .BYTES (EXT_BYTES)
  ) u_ext (
    .core_clk_in (core_clk_in),
    .ce_in       (ce_in),
    .wr_in       (ext_wr),
    .addr_in     (AW'({index, lane_sel})),
    .wdata_in    (s_data),
    .rdata_out   (ext_rdata)
  );

  // ****************************************************************
  // Read data
  // ****************************************************************

  logic       ext_ok_q;
  logic [7:0] next_rdata;
  logic       status_view;

  assign status_view = CHANNEL_CHECK_SIGNAL_IMPL & ~chk_flag & ~chk_ind;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ext_ok_q <= 1'b0;
    end else if (ce_in && start) begin
      ext_ok_q <= ext_ok;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    case (acc_reg)
      `AOCF_REG_ID_LO: next_rdata = ADAPTER_ID[7:0];
      `AOCF_REG_ID_HI: next_rdata = ADAPTER_ID[15:8];
      `AOCF_REG_BYTE1: next_rdata = byte1;
      `AOCF_REG_BYTE2,
      `AOCF_REG_BYTE3: begin
        if (idx_zero) begin
          next_rdata = (acc_reg == `AOCF_REG_BYTE2) ? byte2 : byte3;
        end else begin
          next_rdata = ext_ok_q ? ext_rdata : `AOCF_EXT_EMPTY;
        end
      end
      `AOCF_REG_BYTE4: next_rdata = {chk_flag, chk_ind, byte4_lo};
      `AOCF_REG_IDX_LO: next_rdata = status_view ? chk_status[7:0] : index[7:0];
      `AOCF_REG_IDX_HI: next_rdata = status_view ? chk_status[15:8] : index[15:8];
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      data_out    <= 8'h00;
      data_oe_out <= 1'b0;
    end else if (ce_in) begin
      if (state == AOCF_CAPT && !acc_wr) begin
        data_out    <= next_rdata;
        data_oe_out <= 1'b1;
      end else if (finish) begin
        data_oe_out <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Field outputs and decodes
  // ****************************************************************

  logic card_en;
  logic dev_mode;
  logic io_match;
  logic mem_match;

  assign card_en  = byte1[`AOCF_B1_CARD_EN];
  assign dev_mode = byte2[`AOCF_B2_DEV_MODE];

  // Device-address mode reserves bits 9..8 as zero
  assign io_match = dev_mode ?
    (s_io_addr[15:10] == byte2[`AOCF_B2_DEVADR_MSB:`AOCF_B2_DEVADR_LSB] &&
     s_io_addr[9:8] == 2'h0) :
    (s_io_addr[15:8] == IO_SEL_PAGE &&
     s_io_addr[7:5] == byte1[`AOCF_B1_IOSEL_MSB:`AOCF_B1_IOSEL_LSB]);

  assign mem_match = (s_mem_addr[18:4] == `AOCF_MEM_REGION) &&
    (s_mem_addr[3:0] == byte1[`AOCF_B1_MEMWIN_MSB:`AOCF_B1_MEMWIN_LSB]);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      card_enable_out    <= 1'b0;
      bus_enable_out     <= 1'b0;
      io_addr_select_out <= 3'h0;
      mem_window_out     <= 4'h0;
      arb_level_out      <= 4'h0;
      fairness_en_out    <= 1'b1;
      matched_mem_en_out <= 1'b0;
      streaming_en_out   <= 1'b0;
      dev_addr_out       <= 6'h00;
      io_hit_out         <= 1'b0;
      reg_select_out     <= 8'h00;
      mem_hit_out        <= 1'b0;
    end else if (ce_in) begin
      card_enable_out    <= card_en;
      bus_enable_out     <= card_en | ~s_setup_n;
      io_addr_select_out <= byte1[`AOCF_B1_IOSEL_MSB:`AOCF_B1_IOSEL_LSB];
      mem_window_out     <= byte1[`AOCF_B1_MEMWIN_MSB:`AOCF_B1_MEMWIN_LSB];
      arb_level_out      <= byte3[`AOCF_B3_ARB_MSB:`AOCF_B3_ARB_LSB];
      fairness_en_out    <= byte2[`AOCF_B2_FAIR_EN];
      matched_mem_en_out <= byte4_lo[`AOCF_B4_MATCH_EN];
      streaming_en_out   <= byte3[`AOCF_B3_STREAM_EN];
      dev_addr_out       <= byte2[`AOCF_B2_DEVADR_MSB:`AOCF_B2_DEVADR_LSB];
      io_hit_out         <= card_en & ~s_mio & io_match;
      reg_select_out     <= dev_mode ? s_io_addr[7:0] : {3'h0, s_io_addr[4:0]};
      mem_hit_out        <= card_en & s_mio & mem_match;
    end
  end

  // ****************************************************************
  // Parity, streaming, feedback and channel-check pins
  // ****************************************************************

  logic dpar_en;
  logic apar_en;

  assign dpar_en = byte3[`AOCF_B3_DPAR_EN] & card_en;
  assign apar_en = byte3[`AOCF_B3_APAR_EN] & card_en;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      data_parity_valid_n_out     <= 1'b1;
      address_parity_valid_n_out  <= 1'b1;
      data_parity_check_out       <= 1'b0;
      address_parity_check_out    <= 1'b0;
      streaming_strobe_oe_out     <= 1'b0;
      sfdbk_exception_out         <= 1'b0;
      channel_check_signal_n_out  <= 1'b0;
      channel_check_signal_oe_out <= 1'b0;
    end else if (ce_in) begin
      data_parity_valid_n_out    <= ~(dpar_en & parity_active_in);
      address_parity_valid_n_out <= ~(apar_en & parity_active_in);
      data_parity_check_out      <= dpar_en;
      address_parity_check_out   <= apar_en;
      streaming_strobe_oe_out    <= byte3[`AOCF_B3_STREAM_EN] & card_en & strobe_req_in;
      sfdbk_exception_out        <= byte4_lo[`AOCF_B4_SFDBK_EN] & sfdbk_missing_in;
      channel_check_signal_n_out <= 1'b0;
      // Open drain: pulled low only while the flag shows an exception
      channel_check_signal_oe_out <= CHANNEL_CHECK_SIGNAL_IMPL & ~chk_flag;
    end
  end

endmodule // aocf_top

`default_nettype wire

/* File: inc/aocf_pkg.sv */
// Types shared by the option-select register bank.
// Assumes aocf_regs.svh is on the include path.
`include "aocf_regs.svh"

package aocf_pkg;

  // Setup-cycle sequencing
  typedef enum logic [1:0] {
    AOCF_IDLE,
    AOCF_CAPT,
    AOCF_HOLD
  } aocf_setup_state_t;

endpackage

/* File: inc/aocf_regs.svh */
// Option-select register bank: offsets, field positions, reset values.
// Assumes inclusion by the package and the design files by bare name.
`ifndef AOCF_REGS_SVH
`define AOCF_REGS_SVH

// Setup-cycle register selects (low three address bits)
`define AOCF_REG_ID_LO      3'h0
`define AOCF_REG_ID_HI      3'h1
`define AOCF_REG_BYTE1      3'h2
`define AOCF_REG_BYTE2      3'h3
`define AOCF_REG_BYTE3      3'h4
`define AOCF_REG_BYTE4      3'h5
`define AOCF_REG_IDX_LO     3'h6
`define AOCF_REG_IDX_HI     3'h7

// option_select_byte1
`define AOCF_B1_CARD_EN     0
`define AOCF_B1_IOSEL_LSB   1
`define AOCF_B1_IOSEL_MSB   3
`define AOCF_B1_MEMWIN_LSB  4
`define AOCF_B1_MEMWIN_MSB  7
// option_select_byte2
`define AOCF_B2_DEVADR_LSB  0
`define AOCF_B2_DEVADR_MSB  5
`define AOCF_B2_DEV_MODE    6
`define AOCF_B2_FAIR_EN     7
// option_select_byte3
`define AOCF_B3_ARB_LSB     0
`define AOCF_B3_ARB_MSB     3
`define AOCF_B3_DPAR_EN     4
`define AOCF_B3_APAR_EN     5
`define AOCF_B3_AUTOINC     6
`define AOCF_B3_STREAM_EN   7
// option_select_byte4_check
`define AOCF_B4_MATCH_EN    0
`define AOCF_B4_SFDBK_EN    1
`define AOCF_B4_USER_LSB    2
`define AOCF_B4_USER_MSB    5
`define AOCF_B4_CHK_IND     6
`define AOCF_B4_CHK_FLAG    7

// Reset values
`define AOCF_RST_BYTE1      8'h00
`define AOCF_RST_BYTE2      8'h80
`define AOCF_RST_BYTE3      8'h00
`define AOCF_RST_BYTE4_LO   6'h00
`define AOCF_RST_CHK_FLAG   1'b1
`define AOCF_RST_CHK_IND    1'b1
`define AOCF_RST_INDEX      16'h0000

// Memory window region A31..A17 for 000C0000..000DFFFF
`define AOCF_MEM_REGION     15'h0006
// Out-of-range extension reads
`define AOCF_EXT_EMPTY      8'h00
// Synchroniser idle pattern: select and command high
`define AOCF_PIN_IDLE       48'h6000_0000_0000

`endif

/* File: test/aocf_master.sv */
// System master model issuing single-byte setup cycles.
// Assumes pins change on the falling edge; the bank synchronises them.
`timescale 1ns/1ns
`default_nettype none

module aocf_master (
  input  wire logic        core_clk_in,
  input  wire logic        data_oe_in,
  input  wire logic [7:0]  data_in,
  output var  logic        setup_n_out,
  output var  logic        cmd_n_out,
  output var  logic        write_out,
  output var  logic        m_io_out,
  output var  logic [15:0] addr_out,
  output var  logic [7:0]  data_out
);
  initial begin
    setup_n_out = 1'b1;
    cmd_n_out = 1'b1;
    write_out = 1'b0;
    m_io_out = 1'b0;
    addr_out = 16'h0000;
    data_out = 8'h00;
  end

  // ****
  // Setup cycle
  // ****
  // Upper address bits are junk on purpose: only the low three select
  task automatic access(input logic [2:0] r, input logic w, input logic [7:0] d, output logic [7:0] q);
    @(negedge core_clk_in);
    setup_n_out = 1'b0;
    m_io_out = 1'b0;
    write_out = w;
    addr_out = {13'h1E5B, r};
    data_out = w ? d : ~data_out;
    repeat (3) @(negedge core_clk_in);
    cmd_n_out = 1'b0;
    repeat (8) @(negedge core_clk_in);
    q = data_oe_in ? data_in : 8'hXX;
    cmd_n_out = 1'b1;
    repeat (4) @(negedge core_clk_in);
    setup_n_out = 1'b1;
    data_out = ~data_out;
    repeat (3) @(negedge core_clk_in);
  endtask

  task automatic io(input logic [15:0] a);
    @(negedge core_clk_in);
    m_io_out = 1'b0;
    addr_out = a;
  endtask

  // Memory cycles need the memory side of the select line
  task automatic mio(input logic v);
    @(negedge core_clk_in);
    m_io_out = v;
  endtask
endmodule // aocf_master
`default_nettype wire

/* File: test/aocf_top_props.sv */
// Checker for the option-select bank, watching top-level pins only.
// Assumes a single clock and the synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module aocf_top_props (
  input wire logic        core_clk_in,
  input wire logic        rst_in,
  input wire logic        card_setup_select_n_in,
  input wire logic        cmd_n_in,
  input wire logic        write_in,
  input wire logic        m_io_in,
  input wire logic [31:13] mem_addr_in,
  input wire logic        channel_check_signal_event_in,
  input wire logic        sfdbk_missing_in,
  input wire logic        parity_active_in,
  input wire logic        data_oe_out,
  input wire logic        card_enable_out,
  input wire logic        fairness_en_out,
  input wire logic        streaming_en_out,
  input wire logic        mem_hit_out,
  input wire logic        data_parity_valid_n_out,
  input wire logic        address_parity_valid_n_out,
  input wire logic        data_parity_check_out,
  input wire logic        address_parity_check_out,
  input wire logic        streaming_strobe_oe_out,
  input wire logic        sfdbk_exception_out,
  input wire logic        channel_check_signal_n_out,
  input wire logic        channel_check_signal_oe_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  // ****
  // Assertions
  // ****
  a_reset_dflt: assert property ($past(rst_in) |-> fairness_en_out && !card_enable_out
    && !streaming_en_out && data_parity_valid_n_out && !data_oe_out) else $error("bad value after reset");
  a_strobe_release: assert property (!streaming_en_out && $past(!streaming_en_out)
    |-> !streaming_strobe_oe_out) else $error("strobe driven while streaming off");
  a_dpar_gate: assert property (!data_parity_valid_n_out
    |-> $past(parity_active_in) && data_parity_check_out) else $error("data parity driven while off");
  a_apar_gate: assert property (!address_parity_valid_n_out
    |-> $past(parity_active_in) && address_parity_check_out) else $error("address parity driven while off");
  a_fb_cause: assert property (sfdbk_exception_out |-> $past(sfdbk_missing_in))
    else $error("feedback exception without cause");
  a_read_answer: assert property ($fell(cmd_n_in) && !write_in && !m_io_in && !card_setup_select_n_in
    && $past(!card_setup_select_n_in, 3) |-> ##[2:7] data_oe_out) else $error("setup read not answered");
  a_oe_release: assert property ($rose(cmd_n_in) |-> ##[1:5] !data_oe_out)
    else $error("read data held after command");
  a_chk_cause: assert property ($rose(channel_check_signal_oe_out)
    |-> $past(channel_check_signal_event_in, 2) || $past(channel_check_signal_event_in, 3)) else $error("check line without event");
  a_chk_low: assert property (channel_check_signal_oe_out |-> !channel_check_signal_n_out)
    else $error("check line driven high");
  a_mem_region: assert property (mem_hit_out |-> $past(mem_addr_in[31:17], 3) == 15'h0006)
    else $error("memory hit outside region");

  c_read: cover property ($rose(data_oe_out));
  c_check: cover property ($rose(channel_check_signal_oe_out));
  c_fb: cover property (sfdbk_exception_out);
endmodule // aocf_top_props

bind aocf_top aocf_top_props u_props (.core_clk_in, .rst_in, .card_setup_select_n_in, .cmd_n_in,
  .write_in, .m_io_in, .mem_addr_in, .channel_check_signal_event_in, .sfdbk_missing_in, .parity_active_in,
  .data_oe_out, .card_enable_out, .fairness_en_out, .streaming_en_out, .mem_hit_out,
  .data_parity_valid_n_out, .address_parity_valid_n_out, .data_parity_check_out,
  .address_parity_check_out, .streaming_strobe_oe_out, .sfdbk_exception_out,
  .channel_check_signal_n_out, .channel_check_signal_oe_out);
`default_nettype wire

/* File: test/aocf_top_tb.sv */
// Self-checking bench for the option-select bank with a master model.
// Assumes a 100 MHz clock and a shortened extension store.
`timescale 1ns/1ns
`default_nettype none

module aocf_top_tb;
  logic        core_clk_in;
  logic        rst_in;
  logic        channel_reset_in;
  logic        card_setup_select_n_in;
  logic        cmd_n_in;
  logic        write_in;
  logic        m_io_in;
  logic [15:0] io_addr_in;
  logic [7:0]  data_in;
  logic [31:13] mem_addr_in;
  logic        channel_check_signal_event_in;
  logic [15:0] channel_check_signal_status_in;
  logic        sfdbk_missing_in;
  logic        strobe_req_in;
  logic        parity_active_in;
  logic [7:0]  data_out;
  logic        data_oe_out;
  logic        card_enable_out;
  logic [2:0]  io_addr_select_out;
  logic [3:0]  mem_window_out;
  logic [3:0]  arb_level_out;
  logic        fairness_en_out;
  logic        matched_mem_en_out;
  logic        streaming_en_out;
  logic [5:0]  dev_addr_out;
  logic        io_hit_out;
  logic [7:0]  reg_select_out;
  logic        mem_hit_out;
  logic        data_parity_valid_n_out;
  logic        address_parity_valid_n_out;
  logic        data_parity_check_out;
  logic        address_parity_check_out;
  logic        bus_enable_out;
  logic        ce_in;
  logic        streaming_strobe_oe_out;
  logic        sfdbk_exception_out;
  logic        channel_check_signal_oe_out;
  int          failures;
  int          compares;

  // Identity value is arbitrary
  aocf_top #(.ADAPTER_ID(16'h3C96), .EXT_BYTES(16)) DUT (
    .ce_in, .core_clk_in, .rst_in, .channel_reset_in, .card_setup_select_n_in, .cmd_n_in,
    .write_in, .m_io_in, .io_addr_in, .data_in, .mem_addr_in, .channel_check_signal_event_in, .channel_check_signal_status_in,
    .sfdbk_missing_in, .strobe_req_in, .parity_active_in, .data_out, .data_oe_out, .card_enable_out,
    .bus_enable_out, .io_addr_select_out, .mem_window_out, .arb_level_out, .fairness_en_out,
    .matched_mem_en_out, .streaming_en_out, .dev_addr_out, .io_hit_out, .reg_select_out, .mem_hit_out,
    .data_parity_valid_n_out, .address_parity_valid_n_out, .data_parity_check_out,
    .address_parity_check_out, .streaming_strobe_oe_out, .sfdbk_exception_out,
    .channel_check_signal_n_out(), .channel_check_signal_oe_out);

  aocf_master m (.core_clk_in, .data_oe_in(data_oe_out), .data_in(data_out),
    .setup_n_out(card_setup_select_n_in), .cmd_n_out(cmd_n_in), .write_out(write_in),
    .m_io_out(m_io_in), .addr_out(io_addr_in), .data_out(data_in));

  initial begin
    core_clk_in = 1'b0;
    forever #5 core_clk_in = ~core_clk_in;
  end

  // ****
  // Tasks
  // ****
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_in);
  endtask

  task automatic wr(input logic [2:0] r, input logic [7:0] d);
    logic [7:0] q;
    m.access(r, 1'b1, d, q);
  endtask

  task automatic rd(input logic [2:0] r, input logic [7:0] e);
    logic [7:0] q;
    m.access(r, 1'b0, 8'h00, q);
    chk($sformatf("reg%0d", r), {8'h00, e}, {8'h00, q});
  endtask

  task automatic defaults();
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h80);
    rd(3'h4, 8'h00);
    rd(3'h5, 8'hC0);
    rd(3'h6, 8'h00);
    rd(3'h7, 8'h00);
  endtask

  task automatic conclude();
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Whole sequence needs about 840 cycles
  initial begin
    tick(20000);
    failures++;
    conclude();
  end

  // ****
  // Tests
  // ****
  initial begin
    failures = 0;
    compares = 0;
    rst_in = 1'b1;
    ce_in = 1'b1;
    channel_reset_in = 1'b0;
    mem_addr_in = '0;
    channel_check_signal_event_in = 1'b0;
    channel_check_signal_status_in = 16'h0000;
    sfdbk_missing_in = 1'b0;
    strobe_req_in = 1'b1;
    parity_active_in = 1'b1;
    tick(16);
    rst_in = 1'b0;
    tick(2);
    defaults();
    chk("fair", 16'h1, fairness_en_out);
    chk("dpv", 16'h1, data_parity_valid_n_out);
    chk("ben", 16'h0, bus_enable_out);
    rd(3'h0, 8'h96);
    wr(3'h0, 8'h11);
    rd(3'h0, 8'h96);
    wr(3'h2, 8'hA7);
    rd(3'h2, 8'hA7);
    chk("win", 16'hA, mem_window_out);
    chk("iosel", 16'h3, io_addr_select_out);
    chk("card", 16'h1, card_enable_out);
    chk("ben", 16'h1, bus_enable_out);
    m.mio(1'b1);
    mem_addr_in = {15'h0006, 4'hA};
    tick(4);
    chk("mhit", 16'h1, mem_hit_out);
    mem_addr_in = {15'h0006, 4'hB};
    tick(4);
    chk("mmiss", 16'h0, mem_hit_out);
    wr(3'h3, 8'h6D);
    chk("dev", 16'h2D, dev_addr_out);
    chk("fair", 16'h0, fairness_en_out);
    m.io({6'h2D, 2'b00, 8'h55});
    tick(4);
    chk("iohit", 16'h1, io_hit_out);
    chk("rsel", 16'h55, reg_select_out);
    m.io({6'h2D, 2'b01, 8'h55});
    tick(4);
    chk("iomiss", 16'h0, io_hit_out);
    wr(3'h4, 8'h35);
    chk("arb", 16'h5, arb_level_out);
    chk("dpv", 16'h0, data_parity_valid_n_out);
    chk("apv", 16'h0, address_parity_valid_n_out);
    chk("apc", 16'h1, address_parity_check_out);
    chk("sdoe", 16'h0, streaming_strobe_oe_out);
    wr(3'h4, 8'h95);
    chk("apv", 16'h1, address_parity_valid_n_out);
    chk("sdoe", 16'h1, streaming_strobe_oe_out);
    wr(3'h4, 8'h00);
    chk("dpc", 16'h0, data_parity_check_out);
    @(negedge core_clk_in) sfdbk_missing_in = 1'b1;
    @(negedge core_clk_in) chk("fbx", 16'h0, sfdbk_exception_out);
    sfdbk_missing_in = 1'b0;
    wr(3'h5, 8'h03);
    rd(3'h5, 8'hC3);
    chk("mm", 16'h1, matched_mem_en_out);
    @(negedge core_clk_in) sfdbk_missing_in = 1'b1;
    @(negedge core_clk_in) chk("fbx", 16'h1, sfdbk_exception_out);
    sfdbk_missing_in = 1'b0;
    tick(1);
    ce_in = 1'b0;
    sfdbk_missing_in = 1'b1;
    tick(3);
    chk("cefrz", 16'h0, sfdbk_exception_out);
    ce_in = 1'b1;
    sfdbk_missing_in = 1'b0;
    channel_check_signal_status_in = 16'hBEEF;
    @(negedge core_clk_in) channel_check_signal_event_in = 1'b1;
    @(negedge core_clk_in) channel_check_signal_event_in = 1'b0;
    tick(3);
    chk("ckoe", 16'h1, channel_check_signal_oe_out);
    rd(3'h5, 8'h03);
    rd(3'h6, 8'hEF);
    rd(3'h7, 8'hBE);
    wr(3'h5, 8'h83);
    rd(3'h5, 8'hC3);
    chk("ckoe", 16'h0, channel_check_signal_oe_out);
    rd(3'h6, 8'h00);
    wr(3'h4, 8'h40);
    wr(3'h6, 8'h02);
    wr(3'h7, 8'h00);
    wr(3'h3, 8'h11);
    rd(3'h6, 8'h03);
    wr(3'h4, 8'h22);
    rd(3'h6, 8'h04);
    wr(3'h6, 8'h02);
    rd(3'h3, 8'h11);
    rd(3'h4, 8'h22);
    wr(3'h6, 8'h00);
    rd(3'h4, 8'h40);
    channel_reset_in = 1'b1;
    tick(5);
    channel_reset_in = 1'b0;
    tick(4);
    defaults();
    conclude();
  end
endmodule // aocf_top_tb
`default_nettype wire
